// ==== loop_ctrl_pkg.sv ====
// Constants for the power-down and loop mode control bank.
// Assumes a single 125 MHz APB clock domain with active-low async reset.
// Overview of operation
// RULE1: Soft reset bit resets operating logic, keeps register contents; default clear.
// RULE2: Oscillator power-down bit puts the controlled oscillator in deep sleep.
// RULE3: System clock power-down sleeps system clock input and its multiplier PLL.
// RULE4: Reference input power-down sleeps all reference input receivers.
// RULE5: Converter power-down bit sleeps the time-to-digital converter.
// RULE6: Output PLL power-down bit sleeps the output analog PLL.
// RULE7: Distribution power-down bit sleeps the clock distribution outputs.
// RULE8: Full power-down sleeps everything regardless of individual bits.
// RULE9: Forced holdover bit forces holdover whatever the reference state.
// RULE10: Holdover uses history word if present, else free run word.
// RULE11: During forced holdover phase and frequency lock detectors read unlocked.
// RULE12: Forced free run bit uses only the free run tuning word.
// RULE13: Free run wins when free run and holdover are both forced.
// RULE14: Bits 4:2 pick switchover mode; 000 revertive, 001, 010 defined.
// RULE15: Mode 011 is manual select with automatic holdover on failure.
// RULE16: Mode 100 is full manual with no automatic holdover.
// RULE17: In full manual mode bit 0 picks reference A or B.
// RULE18: Software writes zeros to reserved bits, avoids unused mode codes.
package loop_ctrl_pkg;
    // ==========================================================
    // Register map
    localparam logic [11:0] pd_index    = 12'hA00;
    localparam logic [11:0] loop_index  = 12'hA01;
    localparam logic [13:0] pd_addr     = 14'(pd_index * 4);
    localparam logic [13:0] loop_addr   = 14'(loop_index * 4);
    localparam logic [7:0]  pd_reset    = 8'h00;
    localparam logic [7:0]  loop_reset  = 8'h00;
    localparam logic [7:0]  loop_wmask  = 8'h7D;
    // ==========================================================
    // Field positions
    localparam int soft_reset_bit  = 7;
    localparam int osc_pd_bit      = 6;
    localparam int system_clock_input_pd_bit   = 5;
    localparam int ref_pd_bit      = 4;
    localparam int tdc_pd_bit      = 3;
    localparam int output_analog_pll_pd_bit     = 2;
    localparam int dist_pd_bit     = 1;
    localparam int full_pd_bit     = 0;
    localparam int holdover_bit    = 6;
    localparam int freerun_bit     = 5;
    localparam int mode_lsb        = 2;
    localparam int manual_ref_bit  = 0;
    // ==========================================================
    // Switchover modes and loop states
    typedef enum logic [2:0] {
        mode_revertive     = 3'h0,
        mode_nonrevertive  = 3'h1,
        mode_manual_fallbk = 3'h2,
        mode_manual_hold   = 3'h3,
        mode_full_manual   = 3'h4
    } switch_mode_e;
    typedef enum logic [1:0] {
        st_locked   = 2'h0,
        st_holdover = 2'h1,
        st_freerun  = 2'h3
    } loop_state_e;
    localparam logic [1:0] tw_history = 2'h0;
    localparam logic [1:0] tw_freerun = 2'h1;
    localparam logic [1:0] tw_loop    = 2'h2;
    // Soft reset pulse length in cycles
    localparam logic [3:0] soft_reset_cycles = 4'h4;
endpackage : loop_ctrl_pkg

// ==== ctrl_link_if.sv ====
// Interface between register file, power decoder and loop selector.
// Assumes all parties share the APB clock.
interface ctrl_link_if;
    logic [7:0] pd_reg;
    logic [7:0] loop_reg;
    logic       soft_reset_active;
    modport regs (output pd_reg, loop_reg, soft_reset_active);
    modport user (input pd_reg, loop_reg, soft_reset_active);
endinterface : ctrl_link_if

// ==== power_decode.sv ====
// Power-down decoder: registered sleep controls per sub-block.
// Assumes controls are read from the register bank through ctrl_link_if.
module power_decode
    import loop_ctrl_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    ctrl_link_if.user   link,
    output logic [5:0]  sleep
);
    typedef struct packed {
        logic [5:0] sleep;
    } pd_state_s;
    pd_state_s state;
    pd_state_s next_state;
    logic      full;
    logic [5:0] indiv;
    assign full  = link.pd_reg[full_pd_bit];
    assign indiv = link.pd_reg[osc_pd_bit:dist_pd_bit];
    // ==========================================================
    // Sleep per sub-block, full power-down overriding
    always_comb begin
        next_state = state;
        for (int i = 0; i < 6; i++) begin
            next_state.sleep[i] = indiv[i] | full; // RULE8
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign sleep = state.sleep;
    a_full_sleeps_all: // RULE8
        assert property (@(posedge pclk) disable iff (!presetn)
            full |=> sleep == 6'h3F) else $error("full power-down missed");
endmodule : power_decode

// ==== loop_ctrl_regs.sv ====
// Power-down and loop mode control bank with APB slave.
// Assumes a single APB master; loop status comes from the loop controller.
//
// Register access over APB was decided locally.
module loop_ctrl_regs
    import loop_ctrl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ref_failed,
    input  wire logic        auto_ref_b,
    input  wire logic        history_valid,
    input  wire logic        phase_lock_raw,
    input  wire logic        freq_lock_raw,
    output logic             op_reset,
    output logic             osc_sleep,
    output logic             system_clock_input_sleep,
    output logic             system_clock_input_pll_sleep,
    output logic             ref_rx_sleep,
    output logic             tdc_sleep,
    output logic             output_analog_pll_sleep,
    output logic             dist_sleep,
    output logic             device_sleep,
    output logic [1:0]       loop_state,
    output logic [1:0]       tw_source,
    output logic [2:0]       switch_mode,
    output logic             manual_select,
    output logic             ref_select_b,
    output logic             phase_locked,
    output logic             freq_locked
);
    ctrl_link_if link ();
    logic [5:0] sleep;

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]  pd_reg;
        logic [7:0]  loop_reg;
        logic [3:0]  rst_cnt;
        logic        op_reset;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [1:0]  loop_state;
        logic [1:0]  tw_source;
        logic [2:0]  switch_mode;
        logic        manual_select;
        logic        ref_select_b;
        logic        phase_locked;
        logic        freq_locked;
        logic        device_sleep;
    } regs_state_s;
    regs_state_s state;
    regs_state_s next_state;

    logic        access;
    logic        hit_pd;
    logic        hit_loop;
    logic        holdover_req;
    logic        freerun_req;
    logic [2:0]  mode_f;
    loop_state_e next_loop;

    assign access   = psel && penable && state.pready;
    assign hit_pd   = paddr[13:0] == pd_addr && paddr[31:14] == '0;
    assign hit_loop = paddr[13:0] == loop_addr && paddr[31:14] == '0;
    assign holdover_req = state.loop_reg[holdover_bit];
    assign freerun_req  = state.loop_reg[freerun_bit];
    assign mode_f       = state.loop_reg[mode_lsb +: 3];

    // ==========================================================
    // Loop state selection
    always_comb begin
        if (freerun_req) begin
            next_loop = st_freerun; // RULE12 RULE13
        end else if (holdover_req) begin
            next_loop = st_holdover; // RULE9
        end else begin
            case (mode_f)
                mode_full_manual: next_loop = st_locked; // RULE16
                3'h5, 3'h6, 3'h7: next_loop = st_locked;
                default: begin
                    // Auto modes and 011 fall back to holdover on failure
                    next_loop = ref_failed ? st_holdover : st_locked; // RULE15
                end
            endcase
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_state = state;
        next_state.pready  = 1'b0;
        next_state.pslverr = 1'b0;
        // One wait state: answer at the edge after access begins
        if (psel && penable && !state.pready) begin
            next_state.pready  = 1'b1;
            next_state.pslverr = !(hit_pd || hit_loop);
            next_state.prdata  = '0;
            if (!pwrite && hit_pd) begin
                next_state.prdata = {24'h0, state.pd_reg};
            end else if (!pwrite && hit_loop) begin
                next_state.prdata = {24'h0, state.loop_reg};
            end
        end
        if (access && pwrite && pstrb[0]) begin
            if (hit_pd) begin
                next_state.pd_reg = pwdata[7:0];
            end
            if (hit_loop) begin
                // Reserved bits 7 and 1 stay zero
                next_state.loop_reg = pwdata[7:0] & loop_wmask; // RULE18
            end
        end
        // Soft reset: pulse operating logic, registers untouched
        if (state.pd_reg[soft_reset_bit]) begin
            next_state.pd_reg[soft_reset_bit] = 1'b0; // RULE1
            next_state.rst_cnt = soft_reset_cycles;
        end else if (state.rst_cnt != 4'h0) begin
            next_state.rst_cnt = state.rst_cnt - 4'h1;
        end
        next_state.op_reset = state.pd_reg[soft_reset_bit]
                              || state.rst_cnt > 4'h1; // RULE1
        if (state.op_reset) begin
            next_state.loop_state   = st_freerun;
            next_state.tw_source    = tw_freerun;
            next_state.phase_locked = 1'b0;
            next_state.freq_locked  = 1'b0;
        end else begin
            next_state.loop_state = next_loop;
            case (next_loop)
                st_freerun:  next_state.tw_source = tw_freerun; // RULE12
                st_holdover: begin
                    next_state.tw_source = history_valid
                                           ? tw_history
                                           : tw_freerun; // RULE10
                end
                default:     next_state.tw_source = tw_loop;
            endcase
            // Detectors forced unlocked in forced holdover
            next_state.phase_locked = phase_lock_raw
                                      && !(holdover_req && !freerun_req); // RULE11
            next_state.freq_locked  = freq_lock_raw
                                      && !(holdover_req && !freerun_req); // RULE11
        end
        next_state.switch_mode   = mode_f; // RULE14
        next_state.manual_select = mode_f == mode_full_manual;
        // Full manual uses the register bit, else the auto choice
        next_state.ref_select_b  = (mode_f == mode_full_manual)
                                   ? state.loop_reg[manual_ref_bit]
                                   : auto_ref_b; // RULE17
        next_state.device_sleep  = state.pd_reg[full_pd_bit]; // RULE8
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= '0;
            state.pd_reg   <= pd_reset;
            state.loop_reg <= loop_reset;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Sub-block connections
    assign link.pd_reg            = state.pd_reg;
    assign link.loop_reg          = state.loop_reg;
    assign link.soft_reset_active = state.op_reset;

    power_decode u_power (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (link.user),
        .sleep   (sleep)
    );

    assign prdata           = state.prdata;
    assign pready           = state.pready;
    assign pslverr          = state.pslverr;
    assign op_reset         = state.op_reset;
    assign osc_sleep        = sleep[5]; // RULE2
    assign system_clock_input_sleep     = sleep[4]; // RULE3
    assign system_clock_input_pll_sleep = sleep[4]; // RULE3
    assign ref_rx_sleep     = sleep[3]; // RULE4
    assign tdc_sleep        = sleep[2]; // RULE5
    assign output_analog_pll_sleep       = sleep[1]; // RULE6
    assign dist_sleep       = sleep[0]; // RULE7
    assign device_sleep     = state.device_sleep;
    assign loop_state       = state.loop_state;
    assign tw_source        = state.tw_source;
    assign switch_mode      = state.switch_mode;
    assign manual_select    = state.manual_select;
    assign ref_select_b     = state.ref_select_b;
    assign phase_locked     = state.phase_locked;
    assign freq_locked      = state.freq_locked;

    // ==========================================================
    // Checks
    // One clock and one reset for every check below
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_soft_write;
        access && pwrite && pstrb[0] && hit_pd && pwdata[soft_reset_bit];
    endsequence
    a_soft_reset_pulse: // RULE1
        assert property (s_soft_write ##1 1'b1 |=> op_reset [*4])
        else $error("soft reset pulse wrong");
    a_soft_keeps_regs: // RULE1
        assert property (op_reset && !access |=>
            $stable(state.loop_reg) && $stable(state.pd_reg[6:0]))
        else $error("soft reset touched registers");
    // Forcing lags the pulse by one register stage
    a_soft_forces: // RULE1
        assert property (op_reset |=> loop_state == st_freerun
            && !phase_locked && !freq_locked)
        else $error("soft reset left loop running");
    a_osc_sleep: // RULE2
        assert property (state.pd_reg[osc_pd_bit] |=> osc_sleep)
        else $error("oscillator not asleep");
    a_system_clock_input_sleep: // RULE3
        assert property (1'b1 |=> system_clock_input_pll_sleep == system_clock_input_sleep
            && system_clock_input_sleep == $past(state.pd_reg[system_clock_input_pd_bit]
            | state.pd_reg[full_pd_bit]))
        else $error("system clock sleep wrong");
    a_ref_sleep: // RULE4
        assert property (state.pd_reg[ref_pd_bit] |=> ref_rx_sleep)
        else $error("reference receivers awake");
    a_tdc_sleep: // RULE5
        assert property (state.pd_reg[tdc_pd_bit] |=> tdc_sleep)
        else $error("converter awake");
    a_output_analog_pll_sleep: // RULE6
        assert property (state.pd_reg[output_analog_pll_pd_bit] |=> output_analog_pll_sleep)
        else $error("output PLL awake");
    a_dist_sleep: // RULE7
        assert property (state.pd_reg[dist_pd_bit] |=> dist_sleep)
        else $error("distribution awake");
    a_holdover_force: // RULE9 RULE11
        assert property (holdover_req && !freerun_req && !op_reset |=>
            loop_state == st_holdover && !phase_locked && !freq_locked)
        else $error("forced holdover not taken");
    a_holdover_word: // RULE10
        assert property (holdover_req && !freerun_req && !op_reset |=>
            tw_source == ($past(history_valid) ? tw_history : tw_freerun))
        else $error("holdover word source wrong");
    a_freerun_wins: // RULE12 RULE13
        assert property (freerun_req && !op_reset |=>
            loop_state == st_freerun && tw_source == tw_freerun)
        else $error("free run not taken");
    a_mode_out: // RULE14
        assert property (1'b1 |=> switch_mode == $past(mode_f))
        else $error("switch mode not passed");
    a_auto_holdover: // RULE15
        assert property (mode_f == mode_manual_hold && ref_failed
            && !holdover_req && !freerun_req && !op_reset
            |=> loop_state == st_holdover)
        else $error("no auto holdover");
    a_no_auto_hold: // RULE16
        assert property (mode_f == mode_full_manual && !holdover_req
            && !freerun_req && !op_reset |=> loop_state == st_locked)
        else $error("full manual left lock");
    a_manual_ref: // RULE17
        assert property (mode_f == mode_full_manual |=>
            ref_select_b == $past(state.loop_reg[manual_ref_bit]))
        else $error("manual reference wrong");
endmodule : loop_ctrl_regs

// ==== power_down_and_loop_mode_control_tb.sv ====
// Self-checking testbench for the power-down and loop mode control bank.
// Assumes loop_ctrl_pkg is compiled first and APB slave answers with pready.
module power_down_and_loop_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import loop_ctrl_pkg::*;

    // ==========================================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr;
    logic        ref_failed, auto_ref_b, history_valid;
    logic        phase_lock_raw, freq_lock_raw;
    logic        op_reset, osc_sleep, system_clock_input_sleep, system_clock_input_pll_sleep;
    logic        ref_rx_sleep, tdc_sleep, output_analog_pll_sleep, dist_sleep;
    logic        device_sleep, manual_select, ref_select_b;
    logic        phase_locked, freq_locked;
    logic [1:0]  loop_state, tw_source;
    logic [2:0]  switch_mode;
    int          n_mismatch, num_checks, cycles, hi_count;
    logic [31:0] rd;
    logic        err;
    logic        sr_prev;
    logic [7:0]  pd_v, lp_v;

    loop_ctrl_regs uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_failed(ref_failed), .auto_ref_b(auto_ref_b),
        .history_valid(history_valid), .phase_lock_raw(phase_lock_raw),
        .freq_lock_raw(freq_lock_raw), .op_reset(op_reset),
        .osc_sleep(osc_sleep), .system_clock_input_sleep(system_clock_input_sleep),
        .system_clock_input_pll_sleep(system_clock_input_pll_sleep), .ref_rx_sleep(ref_rx_sleep),
        .tdc_sleep(tdc_sleep), .output_analog_pll_sleep(output_analog_pll_sleep),
        .dist_sleep(dist_sleep), .device_sleep(device_sleep),
        .loop_state(loop_state), .tw_source(tw_source),
        .switch_mode(switch_mode), .manual_select(manual_select),
        .ref_select_b(ref_select_b), .phase_locked(phase_locked),
        .freq_locked(freq_locked)
    );

    // ==========================================================
    // Clock, reset and hang guard
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Ceiling well above the roughly 1300 cycles the tests need
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Holds the request until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [31:0] addr,
                       input logic [31:0] data, input logic [3:0] strb,
                       output logic [31:0] rdata, output logic slverr);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        slverr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [31:0] addr, input logic [7:0] v);
        apb(1'b1, addr, {24'h000000, v}, 4'hF, rd, err);
    endtask : wr_reg

    // Expected outputs worked out from both register values and inputs
    task automatic check_outs(input logic [7:0] pd, input logic [7:0] lp);
        logic       fr;
        logic       ho;
        logic       gate;
        logic [2:0] md;
        md   = lp[4:2];
        fr   = lp[5];
        ho   = lp[6] | ((md < 3'h4) & ref_failed);
        gate = lp[6] & ~fr;
        chk("osc_sleep", osc_sleep, pd[6] | pd[0]);
        chk("system_clock_input_sleep", system_clock_input_sleep, pd[5] | pd[0]);
        chk("system_clock_input_pll_sleep", system_clock_input_pll_sleep, pd[5] | pd[0]);
        chk("ref_rx_sleep", ref_rx_sleep, pd[4] | pd[0]);
        chk("tdc_sleep", tdc_sleep, pd[3] | pd[0]);
        chk("output_analog_pll_sleep", output_analog_pll_sleep, pd[2] | pd[0]);
        chk("dist_sleep", dist_sleep, pd[1] | pd[0]);
        chk("device_sleep", device_sleep, pd[0]);
        chk("loop_state", loop_state,
            fr ? 2'h3 : (ho ? 2'h1 : 2'h0));
        chk("tw_source", tw_source, fr ? 2'h1 :
            (ho ? (history_valid ? 2'h0 : 2'h1) : 2'h2));
        chk("phase_locked", phase_locked, phase_lock_raw & ~gate);
        chk("freq_locked", freq_locked, freq_lock_raw & ~gate);
        chk("switch_mode", switch_mode, md);
        chk("manual_select", manual_select, md == 3'h4);
        chk("ref_select_b", ref_select_b,
            (md == 3'h4) ? lp[0] : auto_ref_b);
    endtask : check_outs

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // ==========================================================
    // Main sequence
    initial begin
        n_mismatch = 0;
        num_checks = 0;
        cycles = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        {ref_failed, auto_ref_b, history_valid} = 3'h0;
        {phase_lock_raw, freq_lock_raw} = 2'h3;
        void'($urandom(70921));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and access kinds
        apb(1'b0, 32'(pd_addr), 32'h0, 4'hF, rd, err);
        chk("pd_reset", rd, 32'h00000000);
        apb(1'b0, 32'(loop_addr), 32'h0, 4'hF, rd, err);
        chk("loop_reset", rd, 32'h00000000);
        repeat (3) @(posedge pclk);
        check_outs(8'h00, 8'h00);
        // Unmapped place: refused, no side effect
        apb(1'b1, 32'h00002808, 32'h000000FF, 4'hF, rd, err);
        chk("unmapped_err", err, 1'b1);
        apb(1'b0, 32'h00002808, 32'h0, 4'hF, rd, err);
        chk("unmapped_rd", rd, 32'h00000000);
        // Reserved loop bits read back zero
        wr_reg(32'(loop_addr), 8'hA3);
        apb(1'b0, 32'(loop_addr), 32'h0, 4'hF, rd, err);
        chk("loop_reserved", rd, 32'h00000021);
        // Random traffic with corner modes cycled
        for (int i = 0; i < 60; i++) begin
            pd_v = 8'($urandom) & 8'h7F;
            lp_v = {1'b0, 2'($urandom), 3'(i % 5),
                    1'b0, 1'($urandom)};
            if (i < 4)
                lp_v[6:5] = 2'(i);
            @(posedge pclk);
            {ref_failed, auto_ref_b, history_valid} <= 3'($urandom);
            {phase_lock_raw, freq_lock_raw} <= 2'($urandom);
            wr_reg(32'(pd_addr), pd_v);
            wr_reg(32'(loop_addr), lp_v);
            repeat (3) @(posedge pclk);
            check_outs(pd_v, lp_v);
            apb(1'b0, 32'(pd_addr), 32'h0, 4'hF, rd, err);
            chk("pd_read", rd, {24'h0, pd_v});
            apb(1'b0, 32'(loop_addr), 32'h0, 4'hF, rd, err);
            chk("loop_read", rd, {24'h0, lp_v});
        end
        // Write with strobe off is ignored
        apb(1'b1, 32'(pd_addr), 32'h0000007F, 4'h0, rd, err);
        apb(1'b0, 32'(pd_addr), 32'h0, 4'hF, rd, err);
        chk("pd_nostrb", rd, {24'h0, pd_v});
        // Soft reset: pulse, locks held low, registers kept
        @(posedge pclk);
        {phase_lock_raw, freq_lock_raw} <= 2'h3;
        wr_reg(32'(loop_addr), 8'h11);
        wr_reg(32'(pd_addr), 8'h84);
        hi_count = 0;
        sr_prev = 1'b0;
        repeat (12) begin
            @(negedge pclk);
            // Forced outputs follow the pulse one register stage later
            if (sr_prev === 1'b1) begin
                chk("sr_state", loop_state, 2'h3);
                chk("sr_lock", phase_locked | freq_locked, 1'b0);
            end
            if (op_reset === 1'b1)
                hi_count = hi_count + 1;
            sr_prev = op_reset;
        end
        chk("sr_pulse", hi_count, 4);
        apb(1'b0, 32'(pd_addr), 32'h0, 4'hF, rd, err);
        chk("sr_pd_kept", rd, 32'h00000004);
        apb(1'b0, 32'(loop_addr), 32'h0, 4'hF, rd, err);
        chk("sr_loop_kept", rd, 32'h00000011);
        repeat (3) @(posedge pclk);
        check_outs(8'h04, 8'h11);
        conclude();
    end
endmodule : power_down_and_loop_mode_control_tb
